// ---- uls_top.sv ----
`timescale 1ns/1ps
module uls_top #(
  parameter int DEPTH = uls_pkg::RX_DEPTH
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        rx_char_valid,
  input  wire logic [7:0]  rx_char_data,
  input  wire logic        rx_char_perr,
  input  wire logic        tx_holding_empty,
  input  wire logic        tx_all_empty,
  input  wire logic        cts_n,
  input  wire logic        dsr_n,
  input  wire logic        ri_n,
  input  wire logic        cd_n,
  output logic             dtr_n,
  output logic             rts_n,
  output logic             aux_output_one_n,
  output logic             aux_output_two_n,
  output logic             modem_irq,
  output logic             irq
);

  localparam int AW = $clog2(DEPTH);

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : ptr_inc

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a[7:2] == ofs[7:2]);
  endfunction : hit

  // bus address phase
  logic        take;
  logic        rd_take;
  logic        wr_take;
  logic [7:0]  a_lo;
  logic        wr_pend_reg;
  logic [7:0]  wr_addr_reg;

  // register state
  logic [4:0]  modem_control_reg;
  logic        fifo_en_reg;
  logic [2:0]  irq_stat_reg;
  logic [2:0]  irq_mask_reg;
  logic [7:0]  line_status;
  logic [7:0]  modem_status;

  // receive path and transmit status
  logic [8:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0]   count_reg;
  logic [AW:0]   cap;
  logic        full;
  logic        push;
  logic        pop;
  logic [7:0]  shift_reg;
  logic        overrun_reg;
  logic        perr_ack_reg;
  logic        head_perr;
  logic        thr_emp_reg;
  logic        tx_emp_reg;

  // modem inputs
  logic [3:0]  pins_s;
  logic [3:0]  level;
  logic [3:0]  level_reg;
  logic [2:0]  primed_reg;
  logic [3:0]  delta_reg;
  logic [3:0]  delta_set;

  logic        rd_line;
  logic        rd_modem;
  logic        rd_irq;
  logic        mode_wr;

  assign take    = hsel && htrans[1] && hready;
  assign rd_take = take && !hwrite;
  assign wr_take = take && hwrite;
  assign a_lo    = haddr[7:0];

  assign rd_line  = rd_take && hit(a_lo, uls_pkg::OFS_LINE_STAT);
  assign rd_modem = rd_take && hit(a_lo, uls_pkg::OFS_MODEM_ST);
  assign rd_irq   = rd_take && hit(a_lo, uls_pkg::OFS_IRQ_STAT);
  assign mode_wr  = wr_pend_reg && hit(wr_addr_reg, uls_pkg::OFS_FIFO_CTL)
                    && (hwdata[uls_pkg::FC_ENABLE] != fifo_en_reg);

  // write data arrives one cycle after the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= wr_take;
      if (wr_take) begin
        wr_addr_reg <= a_lo;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      modem_control_reg <= uls_pkg::MC_RESET;
      fifo_en_reg       <= 1'b0;
      irq_mask_reg      <= uls_pkg::IRQ_RESET;
    end else if (wr_pend_reg) begin
      if (hit(wr_addr_reg, uls_pkg::OFS_MODEM_CTL)) begin
        modem_control_reg <= hwdata[4:0];
      end
      if (hit(wr_addr_reg, uls_pkg::OFS_FIFO_CTL)) begin
        fifo_en_reg <= hwdata[uls_pkg::FC_ENABLE];
      end
      if (hit(wr_addr_reg, uls_pkg::OFS_IRQ_MASK)) begin
        irq_mask_reg <= hwdata[2:0];
      end
    end
  end

  // without the fifo the holding register is a one-entry queue
  assign cap  = fifo_en_reg ? (AW+1)'(DEPTH) : (AW+1)'(1);
  assign full = (count_reg >= cap);
  assign push = rx_char_valid && !full;
  assign pop  = rd_take && hit(a_lo, uls_pkg::OFS_RX_DATA)
                && (count_reg != '0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_reg <= 8'h00;
    end else if (rx_char_valid) begin
      shift_reg <= rx_char_data;
    end
  end

  always_ff @(posedge hclk) begin
    if (push) begin
      mem[wr_ptr_reg] <= {rx_char_perr, rx_char_data};
    end
  end

  // a mode change flushes the queue so stale bytes never surface
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (mode_wr) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      end
      if (pop) begin
        rd_ptr_reg <= ptr_inc(rd_ptr_reg);
      end
      if (push && !pop) begin
        count_reg <= count_reg + (AW+1)'(1);
      end else if (pop && !push) begin
        count_reg <= count_reg - (AW+1)'(1);
      end
    end
  end

  // overrun: a new arrival while full beats the read clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overrun_reg <= 1'b0;
    end else if (rx_char_valid && full) begin
      overrun_reg <= 1'b1;
    end else if (rd_line) begin
      overrun_reg <= 1'b0;
    end
  end

  // parity tracks the head entry; a status read hides it until
  // the next character moves to the head
  assign head_perr = (count_reg != '0) && mem[rd_ptr_reg][8];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      perr_ack_reg <= 1'b0;
    end else if (pop || mode_wr) begin
      perr_ack_reg <= 1'b0;
    end else if (rd_line) begin
      perr_ack_reg <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      thr_emp_reg <= uls_pkg::LS_RESET[uls_pkg::LS_THR_EMP];
      tx_emp_reg  <= uls_pkg::LS_RESET[uls_pkg::LS_TX_EMP];
    end else begin
      thr_emp_reg <= tx_holding_empty;
      tx_emp_reg  <= tx_all_empty;
    end
  end

  always_comb begin
    line_status                      = 8'h00;
    line_status[uls_pkg::LS_READY]   = (count_reg != '0);
    line_status[uls_pkg::LS_OVERRUN] = overrun_reg;
    line_status[uls_pkg::LS_PARITY]  = head_perr && !perr_ack_reg;
    line_status[uls_pkg::LS_THR_EMP] = thr_emp_reg;
    line_status[uls_pkg::LS_TX_EMP]  = tx_emp_reg;
  end

  uls_sync #(
    .WIDTH (uls_pkg::SYNC_WIDTH)
  ) u_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in ({cd_n, ri_n, dsr_n, cts_n}),
    .sync_out (pins_s)
  );

  // level order is {cd, ri, dsr, cts}, matching status bits 7..4
  always_comb begin
    if (modem_control_reg[uls_pkg::MC_LOOP]) begin
      level = {modem_control_reg[uls_pkg::MC_AUX2],
               modem_control_reg[uls_pkg::MC_AUX1],
               modem_control_reg[uls_pkg::MC_DTR],
               modem_control_reg[uls_pkg::MC_RTS]};
    end else begin
      level = ~pins_s;
    end
  end

  // deltas wait until synced pin levels reach level_reg, else the
  // synchroniser's idle reset value would look like a change
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level_reg  <= 4'h0;
      primed_reg <= 3'h0;
    end else begin
      level_reg  <= level;
      primed_reg <= {primed_reg[1:0], 1'b1};
    end
  end

  always_comb begin
    delta_set = 4'h0;
    if (primed_reg[2]) begin
      delta_set[uls_pkg::MS_D_CTS] = level[0] != level_reg[0];
      delta_set[uls_pkg::MS_D_DSR] = level[1] != level_reg[1];
      delta_set[uls_pkg::MS_E_RI]  = level_reg[2] && !level[2];
      delta_set[uls_pkg::MS_D_CD]  = level[3] != level_reg[3];
    end
  end

  // a change in the same cycle as the read survives the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      delta_reg <= uls_pkg::MS_DELTA_RESET;
    end else if (rd_modem) begin
      delta_reg <= delta_set;
    end else begin
      delta_reg <= delta_reg | delta_set;
    end
  end

  assign modem_status = {level_reg, delta_reg};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_reg <= uls_pkg::IRQ_RESET;
    end else begin
      irq_stat_reg <= (rd_irq ? 3'h0 : irq_stat_reg)
                      | {|delta_set,
                         rx_char_valid && (full || rx_char_perr),
                         push};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq       <= 1'b0;
      modem_irq <= 1'b0;
    end else begin
      irq       <= |(irq_stat_reg & irq_mask_reg);
      modem_irq <= |delta_reg;
    end
  end

  // pins are active low, so a cleared control bit idles them high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dtr_n            <= 1'b1;
      rts_n            <= 1'b1;
      aux_output_one_n <= 1'b1;
      aux_output_two_n <= 1'b1;
    end else begin
      dtr_n            <= ~modem_control_reg[uls_pkg::MC_DTR];
      rts_n            <= ~modem_control_reg[uls_pkg::MC_RTS];
      aux_output_one_n <= ~modem_control_reg[uls_pkg::MC_AUX1];
      aux_output_two_n <= ~modem_control_reg[uls_pkg::MC_AUX2];
    end
  end

  // zero wait states: read data is latched at the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (rd_take) begin
        hrdata <= 32'h0000_0000;
        if (hit(a_lo, uls_pkg::OFS_RX_DATA)) begin
          hrdata[7:0] <= (count_reg != '0) ? mem[rd_ptr_reg][7:0] : 8'h00;
        end else if (rd_line) begin
          hrdata[7:0] <= line_status;
        end else if (rd_modem) begin
          hrdata[7:0] <= modem_status;
        end else if (hit(a_lo, uls_pkg::OFS_MODEM_CTL)) begin
          hrdata[4:0] <= modem_control_reg;
        end else if (hit(a_lo, uls_pkg::OFS_FIFO_CTL)) begin
          hrdata[0] <= fifo_en_reg;
        end else if (rd_irq) begin
          hrdata[2:0] <= irq_stat_reg;
        end else if (hit(a_lo, uls_pkg::OFS_IRQ_MASK)) begin
          hrdata[2:0] <= irq_mask_reg;
        end else if (hit(a_lo, uls_pkg::OFS_SHIFT_REG)) begin
          hrdata[7:0] <= shift_reg;
        end
      end
    end
  end

endmodule : uls_top

// ---- uls_pkg.sv ----
package uls_pkg;

  // byte offsets on the register bus
  localparam logic [7:0] OFS_RX_DATA   = 8'h00;
  localparam logic [7:0] OFS_LINE_STAT = 8'h04;
  localparam logic [7:0] OFS_MODEM_ST  = 8'h08;
  localparam logic [7:0] OFS_MODEM_CTL = 8'h0c;
  localparam logic [7:0] OFS_FIFO_CTL  = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h18;
  localparam logic [7:0] OFS_SHIFT_REG = 8'h1c;

  // line status fields
  localparam int LS_READY   = 0;
  localparam int LS_OVERRUN = 1;
  localparam int LS_PARITY  = 2;
  localparam int LS_THR_EMP = 5;
  localparam int LS_TX_EMP  = 6;
  localparam logic [7:0] LS_RESET = 8'h60;

  // modem control fields
  localparam int MC_DTR  = 0;
  localparam int MC_RTS  = 1;
  localparam int MC_AUX1 = 2;
  localparam int MC_AUX2 = 3;
  localparam int MC_LOOP = 4;
  localparam logic [4:0] MC_RESET = 5'h00;

  // modem status fields
  localparam int MS_D_CTS = 0;
  localparam int MS_D_DSR = 1;
  localparam int MS_E_RI  = 2;
  localparam int MS_D_CD  = 3;
  localparam int MS_CTS   = 4;
  localparam int MS_DSR   = 5;
  localparam int MS_RI    = 6;
  localparam int MS_CD    = 7;
  localparam logic [3:0] MS_DELTA_RESET = 4'h0;

  // fifo control and interrupt fields
  localparam int FC_ENABLE = 0;
  localparam int IRQ_RX    = 0;
  localparam int IRQ_LINE  = 1;
  localparam int IRQ_MODEM = 2;
  localparam logic [2:0] IRQ_RESET = 3'h0;

  localparam int RX_DEPTH = 16;
  localparam int SYNC_WIDTH = 4;

endpackage : uls_pkg

// ---- uls_sync.sv ----
`timescale 1ns/1ps
module uls_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // inactive modem pins are high, so both stages reset high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_reg <= '1;
      sync_out <= '1;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : uls_sync

// ---- uls_modem_model.sv ----
`timescale 1ns/1ps
module uls_modem_model (
  output logic cts_n,
  output logic dsr_n,
  output logic ri_n,
  output logic cd_n
);
  // order {cd, ri, dsr, cts}; mixed levels so status bits are not all alike
  logic [3:0] lvl = 4'ha;
  assign {cd_n, ri_n, dsr_n, cts_n} = lvl;
  // pins are async to the host, so a change may land anywhere in a cycle
  task automatic flip(input int i, input int dly);
    #(dly) lvl[i] = ~lvl[i];
  endtask : flip
endmodule : uls_modem_model

// ---- uls_assertions.sv ----
`timescale 1ns/1ps
module uls_checker (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        cts_n,
  input wire logic        dsr_n,
  input wire logic        ri_n,
  input wire logic        cd_n,
  input wire logic        dtr_n,
  input wire logic        rts_n,
  input wire logic        aux_output_one_n,
  input wire logic        aux_output_two_n,
  input wire logic        modem_irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic take;
  logic rd;
  logic wr;
  assign take = hsel && htrans[1] && hready;
  assign rd = take && !hwrite;
  assign wr = take && hwrite;

  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  unmapped_zero_a: assert property (rd && haddr[7:0] >= 8'h20 |=> hrdata == 0)
    else $error("unmapped read not zero");
  ls_unused_a: assert property (
    rd && haddr[7:0] == 8'h04 |=> hrdata[31:7] == 0 && hrdata[4:3] == 0)
    else $error("line status unused bits set");
  ms_clear_a: assert property (
    rd && haddr[7:0] == 8'h08 |-> ##2 !modem_irq)
    else $error("modem irq after status read");
  change_irq_a: assert property (
    $changed(cts_n) || $changed(dsr_n) || $changed(cd_n) |-> ##[1:8] modem_irq)
    else $error("level change without modem irq");
  ri_rise_a: assert property ($rose(ri_n) |-> ##[1:8] modem_irq)
    else $error("ring rise without modem irq");
  ri_fall_a: assert property (
    $fell(ri_n) && !modem_irq |=> !modem_irq [*8])
    else $error("ring fall raised modem irq");
  irq_hold_a: assert property (
    $fell(modem_irq) |-> $past(rd && haddr[7:0] == 8'h08, 2))
    else $error("modem irq dropped without read");
  pins_follow_a: assert property (
    wr && haddr[7:0] == 8'h0c |-> ##3
    {aux_output_two_n, aux_output_one_n, rts_n, dtr_n}
      == ~$past(hwdata[3:0], 2))
    else $error("control pins wrong after write");

  cover property (rd && haddr[7:0] == 8'h08 && modem_irq);
  cover property ($rose(ri_n));
  cover property (wr && haddr[7:0] == 8'h0c);
endmodule : uls_checker

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  logic        hclk = 0, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        rxv, rxp, txh, txa, cts_n, dsr_n, ri_n, cd_n;
  logic        dtr_n, rts_n, ao1_n, ao2_n, modem_irq, irq;
  logic [7:0]  rxd;
  logic [3:0]  e, p, v;
  int          bad_count = 0, cmp_count = 0;

  always #5 hclk = ~hclk;
  uls_modem_model m (.cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .cd_n(cd_n));
  uls_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .rx_char_valid(rxv), .rx_char_data(rxd),
    .rx_char_perr(rxp), .tx_holding_empty(txh), .tx_all_empty(txa),
    .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .cd_n(cd_n), .dtr_n(dtr_n),
    .rts_n(rts_n), .aux_output_one_n(ao1_n), .aux_output_two_n(ao2_n),
    .modem_irq(modem_irq), .irq(irq));

  task automatic cmp8(input string nm, input logic [7:0] x,
                      input logic [7:0] g);
    cmp_count++;
    if (g !== x) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, x, g);
    end
  endtask : cmp8

  // one single word transfer; waits on hready, no fixed latency assumed
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [7:0] x,
                    input logic [7:0] k);
    bus(0, a, 0);
    cmp8("hrdata", x & k, r[7:0] & k);
  endtask : rd

  task automatic push(input logic [7:0] d, input logic pe);
    @(posedge hclk);
    rxv <= 1;
    rxd <= d;
    rxp <= pe;
    @(posedge hclk);
    rxv <= 0;
  endtask : push

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  initial begin
    #200000;
    bad_count++;
    conclude();
  end

  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, rxv, rxd, rxp} = 0;
    hsize = 3'b010;
    {txh, txa} = 2'b11;
    hresetn = 0;
    repeat (3) @(posedge hclk);
    cmp8("reset_pins", 8'h0f, {4'h0, dtr_n, rts_n, ao1_n, ao2_n});
    cmp8("reset_irq", 8'h0, {6'h0, modem_irq, irq});
    hresetn <= 1;
    repeat (4) @(posedge hclk);
    rd(8'h04, 8'h60, 8'hff);
    rd(8'h08, 8'h50, 8'hff);
    rd(8'h20, 8'h00, 8'hff);
    $display("test reset done");
    for (int j = 0; j < 2; j++) begin
      bus(1, 8'h18, {29'h0, j[0], 2'h0});
      rd(8'h18, {5'h0, j[0], 2'h0}, 8'hff);
      for (int i = 0; i < 4; i++) begin
        m.flip(i, 3);
        repeat (12) @(posedge hclk);
        p = m.lvl;
        e = (i != 2 || p[2]) ? 4'h1 << i : 4'h0;
        cmp8("modem_irq", {7'h0, |e}, {7'h0, modem_irq});
        cmp8("irq", {7'h0, j[0] & (|e)}, {7'h0, irq});
        rd(8'h08, {~p, e}, 8'hff);
        rd(8'h08, {~p, 4'h0}, 8'hff);
        rd(8'h14, {5'h0, |e, 2'h0}, 8'h04);
      end
    end
    $display("test modem done");
    for (int i = 0; i < 16; i++) begin
      v = i[3:0];
      bus(1, 8'h0c, {27'h0, 1'b1, v});
      repeat (8) @(posedge hclk);
      rd(8'h0c, {3'h0, 1'b1, v}, 8'hff);
      rd(8'h08, {v[3:2], v[0], v[1], 4'h0}, 8'hf0);
      cmp8("pins", {4'h0, ~v}, {4'h0, ao2_n, ao1_n, rts_n, dtr_n});
    end
    bus(1, 8'h0c, 0);
    repeat (8) @(posedge hclk);
    rd(8'h08, 8'h50, 8'hf0);
    $display("test loopback done");
    bus(1, 8'h10, 1);
    for (int i = 0; i < 17; i++) push(8'h10 + i[7:0], i == 0);
    rd(8'h14, 8'h03, 8'h03);
    rd(8'h04, 8'h67, 8'hff);
    rd(8'h1c, 8'h20, 8'hff);
    rd(8'h04, 8'h61, 8'hff);
    for (int i = 0; i < 16; i++) rd(8'h00, 8'h10 + i[7:0], 8'hff);
    rd(8'h04, 8'h60, 8'hff);
    $display("test receive done");
    bus(1, 8'h10, 0);
    push(8'h31, 0);
    push(8'h32, 0);
    rd(8'h04, 8'h63, 8'hff);
    rd(8'h00, 8'h31, 8'hff);
    rd(8'h1c, 8'h32, 8'hff);
    push(8'h33, 1);
    rd(8'h04, 8'h65, 8'hff);
    rd(8'h00, 8'h33, 8'hff);
    rd(8'h04, 8'h60, 8'hff);
    txh <= 1'b0;
    rd(8'h04, 8'h40, 8'hff);
    $display("test holding done");
    conclude();
  end
endmodule : tb_top

bind uls_top uls_checker chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .cd_n(cd_n), .dtr_n(dtr_n),
  .rts_n(rts_n), .aux_output_one_n(aux_output_one_n),
  .aux_output_two_n(aux_output_two_n), .modem_irq(modem_irq));
